// ### obb_params.svh
// Constants for the ordering buffer bridge: widths, field positions, codes.
// Assumes inclusion by bare name from the package and the design files.
`ifndef OBB_PARAMS_SVH
`define OBB_PARAMS_SVH
`define OBB_ID_W        4
`define OBB_ADDR_W      32
`define OBB_DATA_W      32
`define OBB_LEN_W       8
`define OBB_AWU_W       4
`define OBB_WU_W        2
`define OBB_BU_W        2
`define OBB_ARU_W       4
`define OBB_RU_W        2
`define OBB_CACHE_BUF   0
`define OBB_OVL_LSB     12
`define OBB_LOCK_LEGACY 2'h2
`define OBB_LOCK_EXCL   2'h1
`define OBB_RESP_OKAY   2'h0
`endif

// ### obb_pkg.sv
// Types for the ordering buffer bridge: channel carriers and state encodings.
// Assumes obb_params.svh is on the include path.
`default_nettype none
`include "obb_params.svh"
package obb_pkg;
    typedef struct packed {
        logic [`OBB_ID_W-1:0]   id;
        logic [`OBB_ADDR_W-1:0] addr;
        logic [`OBB_LEN_W-1:0]  len;
        logic [2:0]             size;
        logic [1:0]             burst;
        logic [3:0]             cache;
        logic [2:0]             prot;
        logic [`OBB_AWU_W-1:0]  user;
    } obb_aw_t;
    typedef struct packed {
        logic [`OBB_ID_W-1:0]   id;
        logic [`OBB_ADDR_W-1:0] addr;
        logic [`OBB_LEN_W-1:0]  len;
        logic [2:0]             size;
        logic [1:0]             burst;
        logic [3:0]             cache;
        logic [2:0]             prot;
        logic [`OBB_ARU_W-1:0]  user;
    } obb_ar_t;
    typedef struct packed {
        logic [`OBB_DATA_W-1:0]   data;
        logic [`OBB_DATA_W/8-1:0] strb;
        logic                     last;
        logic [`OBB_WU_W-1:0]     user;
    } obb_w_t;
    typedef struct packed {
        logic [`OBB_ID_W-1:0] id;
        logic [1:0]           resp;
        logic [`OBB_BU_W-1:0] user;
    } obb_b_t;
    typedef struct packed {
        logic [`OBB_ID_W-1:0]   id;
        logic [`OBB_DATA_W-1:0] data;
        logic [1:0]             resp;
        logic                   last;
        logic [`OBB_RU_W-1:0]   user;
    } obb_r_t;
    typedef enum logic [4:0] {
        W_IDLE = 5'h01,
        W_ADDR = 5'h02,
        W_DATA = 5'h04,
        W_RESP = 5'h08,
        W_BUP  = 5'h10
    } obb_wst_t;
    typedef enum logic [2:0] {
        R_IDLE = 3'h1,
        R_ADDR = 3'h2,
        R_DATA = 3'h4
    } obb_rst_t;
endpackage
`default_nettype wire

// ### obb_stage.sv
// One-entry registered stage with valid/ready on both sides.
// Assumes same clock on both sides; holds whole beats, never splits them.
`timescale 1ns/1ps
`default_nettype none
module obb_stage #(
    parameter int W = 8
) (
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire logic         ce_in,
    input  wire logic [W-1:0] in_data_in,
    input  wire logic         in_valid_in,
    output logic              in_ready_out,
    output logic [W-1:0]      out_data_out,
    output logic              out_valid_out,
    input  wire logic         out_ready_in
);
    typedef struct packed {
        logic         full;
        logic [W-1:0] data;
    } obb_stg_t;
    obb_stg_t st;
    obb_stg_t next_st;

    // Accept when empty or draining this cycle
    assign in_ready_out  = ce_in && (!st.full || out_ready_in);
    assign out_valid_out = ce_in && st.full;
    assign out_data_out  = st.data;

    // Next state
    always_comb begin
        next_st = st;
        if (out_valid_out && out_ready_in) begin
            next_st.full = 1'b0;
        end
        if (in_valid_in && in_ready_out) begin
            next_st.full = 1'b1;
            next_st.data = in_data_in;
        end
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= '0;
        end else if (ce_in) begin
            st <= next_st;
        end
    end
endmodule
`default_nettype wire

// ### obb_bridge.sv
// Ordering buffer bridge: upstream slave port, downstream master port.
// Assumes upstream and downstream share clk_in; one write and one read
// in flight, early write response for bufferable writes.
`timescale 1ns/1ps
`default_nettype none
`include "obb_params.svh"
module obb_bridge
    import obb_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       ce_in,
    input  wire obb_aw_t    s_aw_in,
    input  wire logic [1:0] s_aw_lock_in,
    input  wire logic       s_aw_valid_in,
    output logic            s_aw_ready_out,
    input  wire obb_w_t     s_w_in,
    input  wire logic       s_w_valid_in,
    output logic            s_w_ready_out,
    output obb_b_t          s_b_out,
    output logic            s_b_valid_out,
    input  wire logic       s_b_ready_in,
    input  wire obb_ar_t    s_ar_in,
    input  wire logic [1:0] s_ar_lock_in,
    input  wire logic       s_ar_valid_in,
    output logic            s_ar_ready_out,
    output obb_r_t          s_r_out,
    output logic            s_r_valid_out,
    input  wire logic       s_r_ready_in,
    output obb_aw_t         m_aw_out,
    output logic            m_aw_lock_out,
    output logic            m_aw_valid_out,
    input  wire logic       m_aw_ready_in,
    output obb_w_t          m_w_out,
    output logic            m_w_valid_out,
    input  wire logic       m_w_ready_in,
    input  wire obb_b_t     m_b_in,
    input  wire logic       m_b_valid_in,
    output logic            m_b_ready_out,
    output obb_ar_t         m_ar_out,
    output logic            m_ar_lock_out,
    output logic            m_ar_valid_out,
    input  wire logic       m_ar_ready_in,
    input  wire obb_r_t     m_r_in,
    input  wire logic       m_r_valid_in,
    output logic            m_r_ready_out,
    input  wire logic       conv_clr_in,
    output logic            conv_flag_out
);
    typedef struct packed {
        obb_wst_t   wst;
        obb_rst_t   rst;
        obb_aw_t    aw;
        logic       aw_lock;
        obb_ar_t    ar;
        logic       ar_lock;
        logic       early;
        obb_b_t     b;
        logic       conv;
    } obb_st_t;

    localparam obb_st_t ST_RST = '{wst: W_IDLE, rst: R_IDLE, default: '0};

    obb_st_t st;
    obb_st_t next_st;
    logic    aw_fire;
    logic    w_fire;
    logic    b_up_fire;
    logic    b_dn_fire;
    logic    ar_fire;
    logic    r_up_fire;
    logic    rd_hazard;
    logic    wq_in_ready;
    logic    rq_in_ready;

    // Legacy two-bit lock to one-bit lock; 10 and reserved 11 go normal
    function automatic logic lock_conv(input logic [1:0] l);
        return l == `OBB_LOCK_EXCL;
    endfunction

    // Conservative overlap: same 4 KB granule, also covers same slave
    function automatic logic overlap(input logic [`OBB_ADDR_W-1:0] a,
                                     input logic [`OBB_ADDR_W-1:0] b);
        return a[`OBB_ADDR_W-1:`OBB_OVL_LSB] == b[`OBB_ADDR_W-1:`OBB_OVL_LSB];
    endfunction

    // Read held off while an overlapping write is in flight, until it is back in W_IDLE
    assign rd_hazard = st.wst != W_IDLE && overlap(s_ar_in.addr, st.aw.addr);

    // Upstream handshakes; one write at a time keeps same-ID order
    assign s_aw_ready_out = ce_in && st.wst == W_IDLE;
    assign s_ar_ready_out = ce_in && st.rst == R_IDLE && !rd_hazard;
    assign s_w_ready_out  = wq_in_ready && st.wst == W_DATA;
    assign s_b_valid_out  = ce_in && st.wst == W_BUP;
    assign s_b_out        = st.b;
    assign aw_fire        = s_aw_valid_in && s_aw_ready_out;
    assign ar_fire        = s_ar_valid_in && s_ar_ready_out;
    assign w_fire         = s_w_valid_in && s_w_ready_out;
    assign b_up_fire      = s_b_valid_out && s_b_ready_in;
    assign r_up_fire      = s_r_valid_out && s_r_ready_in;

    // Downstream address channels straight from held state
    assign m_aw_out       = st.aw;
    assign m_aw_lock_out  = st.aw_lock;
    assign m_aw_valid_out = ce_in && st.wst == W_ADDR;
    assign m_ar_out       = st.ar;
    assign m_ar_lock_out  = st.ar_lock;
    assign m_ar_valid_out = ce_in && st.rst == R_ADDR;
    assign m_b_ready_out  = ce_in && st.wst == W_RESP;
    assign b_dn_fire      = m_b_valid_in && m_b_ready_out;
    assign m_r_ready_out  = rq_in_ready && st.rst == R_DATA;
    assign conv_flag_out  = st.conv;

    // Write data stage: whole beats, strobes untouched
    obb_stage #(.W($bits(obb_w_t))) u_wq (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .in_data_in    (s_w_in),
        .in_valid_in   (s_w_valid_in && st.wst == W_DATA),
        .in_ready_out  (wq_in_ready),
        .out_data_out  (m_w_out),
        .out_valid_out (m_w_valid_out),
        .out_ready_in  (m_w_ready_in)
    );

    // Read data stage back to upstream
    obb_stage #(.W($bits(obb_r_t))) u_rq (
        .clk_in        (clk_in),
        .sys_rst_in    (sys_rst_in),
        .ce_in         (ce_in),
        .in_data_in    (m_r_in),
        .in_valid_in   (m_r_valid_in && st.rst == R_DATA),
        .in_ready_out  (rq_in_ready),
        .out_data_out  (s_r_out),
        .out_valid_out (s_r_valid_out),
        .out_ready_in  (s_r_ready_in)
    );

    // Next state for both directions and the conversion flag
    always_comb begin
        next_st = st;
        case (st.wst)
            W_IDLE: begin
                if (aw_fire) begin
                    next_st.aw      = s_aw_in;
                    next_st.aw_lock = lock_conv(s_aw_lock_in);
                    next_st.wst     = W_ADDR;
                end
            end
            W_ADDR: begin
                if (m_aw_valid_out && m_aw_ready_in) begin
                    next_st.wst = W_DATA;
                end
            end
            W_DATA: begin
                if (w_fire && s_w_in.last) begin
                    next_st.early = st.aw.cache[`OBB_CACHE_BUF];
                    if (st.aw.cache[`OBB_CACHE_BUF]) begin
                        next_st.b   = '{id: st.aw.id, resp: `OBB_RESP_OKAY, user: '0};
                        next_st.wst = W_BUP;
                    end else begin
                        next_st.wst = W_RESP;
                    end
                end
            end
            W_RESP: begin
                if (b_dn_fire) begin
                    next_st.b   = m_b_in;
                    next_st.wst = st.early ? W_IDLE : W_BUP;
                end
            end
            W_BUP: begin
                if (b_up_fire) begin
                    // Early answer still waits for the slave before next write
                    next_st.wst = st.early ? W_RESP : W_IDLE;
                end
            end
            default: begin
                next_st.wst = W_IDLE;
            end
        endcase
        case (st.rst)
            R_IDLE: begin
                if (ar_fire) begin
                    next_st.ar      = s_ar_in;
                    next_st.ar_lock = lock_conv(s_ar_lock_in);
                    next_st.rst     = R_ADDR;
                end
            end
            R_ADDR: begin
                if (m_ar_valid_out && m_ar_ready_in) begin
                    next_st.rst = R_DATA;
                end
            end
            R_DATA: begin
                if (r_up_fire && s_r_out.last) begin
                    next_st.rst = R_IDLE;
                end
            end
            default: begin
                next_st.rst = R_IDLE;
            end
        endcase
        // Sticky flag; a new conversion wins over a clear
        if (conv_clr_in) begin
            next_st.conv = 1'b0;
        end
        if ((aw_fire && s_aw_lock_in == `OBB_LOCK_LEGACY) ||
            (ar_fire && s_ar_lock_in == `OBB_LOCK_LEGACY)) begin
            next_st.conv = 1'b1;
        end
    end

    // State register, frozen while clock enable is low
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st <= ST_RST;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    // Checks
    default clocking obb_cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);

    chk_aw_lock_legacy: assert property (
        aw_fire && s_aw_lock_in == `OBB_LOCK_LEGACY |=> !m_aw_lock_out)
        else $error("legacy write lock not converted to normal");
    chk_ar_lock_legacy: assert property (
        ar_fire && s_ar_lock_in == `OBB_LOCK_LEGACY |=> !m_ar_lock_out)
        else $error("legacy read lock not converted to normal");
    chk_lock_excl_pass: assert property (
        aw_fire && s_aw_lock_in == `OBB_LOCK_EXCL |=> m_aw_lock_out)
        else $error("exclusive write lost its lock bit");
    chk_flag_set_conv: assert property (
        ar_fire && s_ar_lock_in == `OBB_LOCK_LEGACY |=> conv_flag_out)
        else $error("conversion flag not set");
    chk_flag_sticky: assert property (
        conv_flag_out && !conv_clr_in |=> conv_flag_out)
        else $error("conversion flag dropped without clear");
    chk_aw_forward_whole: assert property (
        aw_fire |=> m_aw_out == $past(s_aw_in))
        else $error("write address or user changed on forwarding");
    chk_write_single: assert property (
        aw_fire |=> !s_aw_ready_out [*3])
        else $error("second write accepted too early");
    chk_wresp_id: assert property (
        s_b_valid_out |-> s_b_out.id == st.aw.id)
        else $error("write response carries wrong id");
    chk_early_cache: assert property (
        s_b_valid_out && st.early |-> st.aw.cache[`OBB_CACHE_BUF])
        else $error("early response to non-bufferable write");
    chk_early_drain: assert property (
        b_up_fire && st.early |=> st.wst == W_RESP && !s_aw_ready_out)
        else $error("early write released before slave answered");
    chk_read_hazard: assert property (
        st.wst != W_IDLE && overlap(s_ar_in.addr, st.aw.addr) |-> !s_ar_ready_out)
        else $error("overlapping read passed a pending write");
    chk_read_single: assert property (
        s_r_valid_out |-> st.rst == R_DATA)
        else $error("read data outside its read");

    cov_early_write: cover property (b_up_fire && st.early);
    cov_late_write: cover property (b_up_fire && !st.early);
    cov_read_stall: cover property (s_ar_valid_in && rd_hazard && ce_in);
    cov_conversion: cover property (aw_fire && s_aw_lock_in == `OBB_LOCK_LEGACY);
endmodule
`default_nettype wire

// ### obb_slave_model.sv
// Downstream slave model facing the bridge's master port.
// Assumes one clock; a write lands in memory only at its response handshake.
`timescale 1ns/1ps
`default_nettype none
module obb_slave_model
    import obb_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic [3:0] lat_in,
    input  wire obb_aw_t    aw_in,
    input  wire logic       aw_lock_in,
    input  wire logic       aw_valid_in,
    output logic            aw_ready_out,
    input  wire obb_w_t     w_in,
    input  wire logic       w_valid_in,
    output logic            w_ready_out,
    output obb_b_t          b_out,
    output logic            b_valid_out,
    input  wire logic       b_ready_in,
    input  wire obb_ar_t    ar_in,
    input  wire logic       ar_lock_in,
    input  wire logic       ar_valid_in,
    output logic            ar_ready_out,
    output obb_r_t          r_out,
    output logic            r_valid_out,
    input  wire logic       r_ready_in,
    output logic            aw_lock_out,
    output logic            ar_lock_out,
    output obb_aw_t         aw_out,
    output obb_w_t          w_out,
    output logic [7:0]      clash_out
);
    logic [31:0] mem [16];
    logic        wact, bpend, ract;
    logic [3:0]  wc, rc;
    logic [7:0]  rb;
    obb_ar_t     ar;
    obb_b_t      b;
    obb_r_t      r;
    // Handshakes; idle response lines show inverted values
    assign aw_ready_out = !wact;
    assign w_ready_out  = wact;
    assign b_valid_out  = bpend && (wc == 4'h0);
    assign ar_ready_out = !ract;
    assign r_valid_out  = ract && (rc == 4'h0);
    assign b = '{id: aw_out.id, resp: 2'h0, user: 2'h2};
    assign r = '{id: ar.id, data: mem[ar.addr[5:2] + rb[3:0]], resp: 2'h0, last: rb == ar.len, user: 2'h1};
    assign b_out = b_valid_out ? b : ~b;
    assign r_out = r_valid_out ? r : ~r;
    // Write, response and read sequencing
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {wact, bpend, ract, wc, rc, rb, clash_out} <= '0;
            {aw_out, w_out, ar, aw_lock_out, ar_lock_out} <= '0;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 32'h0000_0000;
            end
        end else begin
            if (wc != 4'h0) begin
                wc <= wc - 4'h1;
            end
            if (aw_valid_in && aw_ready_out) begin
                aw_out      <= aw_in;
                aw_lock_out <= aw_lock_in;
                wact        <= 1'b1;
                if (bpend) begin
                    clash_out <= clash_out + 8'h01;
                end
            end
            if (w_valid_in && w_ready_out && w_in.last) begin
                w_out <= w_in;
                wact  <= 1'b0;
                bpend <= 1'b1;
                wc    <= lat_in;
            end
            if (b_valid_out && b_ready_in) begin
                bpend <= 1'b0;
                for (int i = 0; i < 4; i++) begin
                    if (w_out.strb[i]) begin
                        mem[aw_out.addr[5:2]][8*i +: 8] <= w_out.data[8*i +: 8];
                    end
                end
            end
            if (rc != 4'h0) begin
                rc <= rc - 4'h1;
            end
            if (ar_valid_in && ar_ready_out) begin
                ar          <= ar_in;
                ar_lock_out <= ar_lock_in;
                ract        <= 1'b1;
                rc          <= lat_in;
                rb          <= 8'h00;
            end
            if (r_valid_out && r_ready_in) begin
                if (r.last) begin
                    ract <= 1'b0;
                end else begin
                    rb <= rb + 8'h01;
                    rc <= lat_in;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### obb_bridge_test.sv
// Self-checking bench for the ordering buffer bridge.
// Assumes the package, bridge, stage and slave model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module obb_bridge_test
    import obb_pkg::*;
;
    logic        clk_in = 1'b0, sys_rst_in = 1'b1, ce_in = 1'b1, conv_clr_in = 1'b0;
    logic [3:0]  lat = 4'h6;
    obb_aw_t     s_aw_in = '0, m_aw_out, seen_aw;
    obb_ar_t     s_ar_in = '0, m_ar_out;
    obb_w_t      s_w_in = '0, m_w_out, seen_w;
    logic [1:0]  s_aw_lock_in = 2'h0, s_ar_lock_in = 2'h0;
    logic        s_aw_valid_in = 1'b0, s_w_valid_in = 1'b0, s_ar_valid_in = 1'b0;
    logic        s_b_ready_in = 1'b0, s_r_ready_in = 1'b0;
    obb_b_t      s_b_out, m_b_in;
    obb_r_t      s_r_out, m_r_in;
    logic        s_aw_ready_out, s_w_ready_out, s_b_valid_out, s_ar_ready_out, s_r_valid_out;
    logic        m_aw_lock_out, m_aw_valid_out, m_aw_ready_in, m_w_valid_out, m_w_ready_in;
    logic        m_b_valid_in, m_b_ready_out, m_ar_lock_out, m_ar_valid_out, m_ar_ready_in;
    logic        m_r_valid_in, m_r_ready_out, conv_flag_out, seen_awl, seen_arl;
    logic [7:0]  clash;
    int          failures = 0, num_checks = 0, cycles = 0;

    obb_bridge i_obb_bridge (
        .clk_in, .sys_rst_in, .ce_in, .s_aw_in, .s_aw_lock_in, .s_aw_valid_in, .s_aw_ready_out,
        .s_w_in, .s_w_valid_in, .s_w_ready_out, .s_b_out, .s_b_valid_out, .s_b_ready_in,
        .s_ar_in, .s_ar_lock_in, .s_ar_valid_in, .s_ar_ready_out, .s_r_out, .s_r_valid_out, .s_r_ready_in,
        .m_aw_out, .m_aw_lock_out, .m_aw_valid_out, .m_aw_ready_in, .m_w_out, .m_w_valid_out, .m_w_ready_in,
        .m_b_in, .m_b_valid_in, .m_b_ready_out, .m_ar_out, .m_ar_lock_out, .m_ar_valid_out, .m_ar_ready_in,
        .m_r_in, .m_r_valid_in, .m_r_ready_out, .conv_clr_in, .conv_flag_out
    );
    obb_slave_model i_obb_slave_model (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .lat_in(lat), .aw_in(m_aw_out), .aw_lock_in(m_aw_lock_out),
        .aw_valid_in(m_aw_valid_out), .aw_ready_out(m_aw_ready_in), .w_in(m_w_out), .w_valid_in(m_w_valid_out),
        .w_ready_out(m_w_ready_in), .b_out(m_b_in), .b_valid_out(m_b_valid_in), .b_ready_in(m_b_ready_out),
        .ar_in(m_ar_out), .ar_lock_in(m_ar_lock_out), .ar_valid_in(m_ar_valid_out), .ar_ready_out(m_ar_ready_in),
        .r_out(m_r_in), .r_valid_out(m_r_valid_in), .r_ready_in(m_r_ready_out), .aw_lock_out(seen_awl),
        .ar_lock_out(seen_arl), .aw_out(seen_aw), .w_out(seen_w), .clash_out(clash)
    );

    // Clock and hang guard
    always #2.5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            $display("ERROR timeout expected done seen hang");
            summarize();
        end
    end

    // Compare tasks
    task automatic chk1(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %0b seen %0b", nm, e, g);
        end
    endtask
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One single-beat write; judges response timing, id and sideband
    task automatic wr(input logic [3:0] id, input logic [31:0] a, input logic [3:0] c, input logic [1:0] lk,
                      input logic [31:0] d, input logic [3:0] sb, input logic early);
        obb_aw_t aw;
        int      n;
        aw = '{id: id, addr: a, len: 8'h00, size: 3'h2, burst: 2'h1, cache: c, prot: 3'h0, user: 4'hA};
        n = 0;
        @(posedge clk_in);
        s_aw_in <= aw;
        s_aw_lock_in <= lk;
        s_aw_valid_in <= 1'b1;
        do @(negedge clk_in); while (s_aw_ready_out !== 1'b1);
        @(posedge clk_in);
        s_aw_valid_in <= 1'b0;
        s_w_in <= '{data: d, strb: sb, last: 1'b1, user: 2'h3};
        s_w_valid_in <= 1'b1;
        do @(negedge clk_in); while (s_w_ready_out !== 1'b1);
        @(posedge clk_in);
        s_w_valid_in <= 1'b0;
        s_b_ready_in <= 1'b1;
        do begin @(negedge clk_in); n++; end while (s_b_valid_out !== 1'b1);
        chk1("early_b", early, n <= 3);
        chk32("b_id", 32'(id), 32'(s_b_out.id));
        chk32("b_user", early ? 32'h0 : 32'h2, 32'(s_b_out.user));
        chk32("aw_user", 32'hA, 32'(seen_aw.user));
        @(posedge clk_in);
        s_b_ready_in <= 1'b0;
    endtask

    // One single-beat read; judges data, id, last and sideband
    task automatic rd(input logic [3:0] id, input logic [31:0] a, input logic [1:0] lk, input logic [31:0] d);
        @(posedge clk_in);
        s_ar_in <= '{id: id, addr: a, len: 8'h00, size: 3'h2, burst: 2'h1, cache: 4'h0, prot: 3'h0, user: 4'h5};
        s_ar_lock_in <= lk;
        s_ar_valid_in <= 1'b1;
        do @(negedge clk_in); while (s_ar_ready_out !== 1'b1);
        @(posedge clk_in);
        s_ar_valid_in <= 1'b0;
        s_r_ready_in <= 1'b1;
        do @(negedge clk_in); while (s_r_valid_out !== 1'b1);
        chk32("r_data", d, s_r_out.data);
        chk32("r_id", 32'(id), 32'(s_r_out.id));
        chk1("r_last", 1'b1, s_r_out.last);
        chk32("r_user", 32'h1, 32'(s_r_out.user));
        @(posedge clk_in);
        s_r_ready_in <= 1'b0;
    endtask

    // Responded writes seen by later reads; same-ID order
    task automatic t_order();
        lat <= 4'h6;
        wr(4'h1, 32'h0000_0100, 4'h0, 2'h0, 32'hA5A5_0001, 4'hF, 1'b0);
        wr(4'h1, 32'h0000_0104, 4'h0, 2'h0, 32'hA5A5_0002, 4'hF, 1'b0);
        rd(4'h1, 32'h0000_0100, 2'h0, 32'hA5A5_0001);
        rd(4'h1, 32'h0000_0104, 2'h0, 32'hA5A5_0002);
        rd(4'h2, 32'h0000_0104, 2'h0, 32'hA5A5_0002);
        $display("t_order done");
    endtask

    // Early answers, then overlapping read and same-ID writes
    task automatic t_early();
        lat <= 4'hA;
        wr(4'h3, 32'h0000_0108, 4'h1, 2'h0, 32'h5A5A_0003, 4'hF, 1'b1);
        rd(4'h4, 32'h0000_0108, 2'h0, 32'h5A5A_0003);
        wr(4'h3, 32'h0000_010C, 4'h1, 2'h0, 32'h5A5A_0004, 4'hF, 1'b1);
        wr(4'h3, 32'h0000_0110, 4'h1, 2'h0, 32'h5A5A_0005, 4'hF, 1'b1);
        chk32("clash", 32'h0, 32'(clash));
        rd(4'h3, 32'h0000_0110, 2'h0, 32'h5A5A_0005);
        $display("t_early done");
    endtask

    // Partial strobes pass unchanged and merge at the slave
    task automatic t_strobe();
        lat <= 4'h6;
        wr(4'h5, 32'h0000_0114, 4'h0, 2'h0, 32'hFFFF_FFFF, 4'hF, 1'b0);
        wr(4'h5, 32'h0000_0114, 4'h0, 2'h0, 32'h1234_5678, 4'h3, 1'b0);
        chk32("w_strb", 32'h3, 32'(seen_w.strb));
        chk32("w_user", 32'h3, 32'(seen_w.user));
        rd(4'h5, 32'h0000_0114, 2'h0, 32'hFFFF_5678);
        $display("t_strobe done");
    endtask

    // Every legacy lock code, sticky flag and its clear
    task automatic t_lock();
        lat <= 4'h0;
        for (int k = 0; k < 4; k++) begin
            wr(4'h6, 32'h0000_0118, 4'h1, 2'(k), 32'(k), 4'hF, 1'b1);
            chk1("aw_lock", k == 1, seen_awl);
            chk1("flag", k >= 2, conv_flag_out);
        end
        @(posedge clk_in);
        conv_clr_in <= 1'b1;
        @(posedge clk_in);
        conv_clr_in <= 1'b0;
        @(negedge clk_in);
        chk1("flag_clr", 1'b0, conv_flag_out);
        rd(4'h6, 32'h0000_0118, 2'h2, 32'h0000_0003);
        chk1("ar_lock", 1'b0, seen_arl);
        chk1("flag_rd", 1'b1, conv_flag_out);
        rd(4'h6, 32'h0000_0118, 2'h1, 32'h0000_0003);
        chk1("ar_lock_ex", 1'b1, seen_arl);
        $display("t_lock done");
    endtask

    // Clock enable low freezes handshakes and the flag clear
    task automatic t_hold();
        @(posedge clk_in);
        ce_in <= 1'b0;
        conv_clr_in <= 1'b1;
        repeat (2) @(negedge clk_in);
        chk1("aw_rdy_hold", 1'b0, s_aw_ready_out);
        chk1("ar_rdy_hold", 1'b0, s_ar_ready_out);
        chk1("flag_hold", 1'b1, conv_flag_out);
        @(posedge clk_in);
        ce_in <= 1'b1;
        conv_clr_in <= 1'b0;
        @(negedge clk_in);
        chk1("aw_rdy_run", 1'b1, s_aw_ready_out);
        chk1("flag_kept", 1'b1, conv_flag_out);
        $display("t_hold done");
    endtask

    // Verdict and end of run
    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Reset, then the scenarios in turn
    initial begin
        repeat (6) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_order();
        t_early();
        t_strobe();
        t_lock();
        t_hold();
        summarize();
    end
endmodule
`default_nettype wire
